// ==== design/mpsc_defines.vh ====
// Constants for the maintenance panel sequence control block
`ifndef MPSC_DEFINES_VH
`define MPSC_DEFINES_VH
// ****************************************************************
// Register offsets (word addresses, one 32-bit register each)
// ****************************************************************
`define MPSC_OFF_SEQ      4'h0
`define MPSC_OFF_TIMING   4'h1
`define MPSC_OFF_FUNC     4'h2
`define MPSC_OFF_PADDR    4'h3
`define MPSC_OFF_PHASE    4'h4
`define MPSC_OFF_MODE     4'h5
`define MPSC_OFF_STATUS   4'h6
// ****************************************************************
// Sequence designator bit positions
// ****************************************************************
`define MPSC_SEQ_IO1      0
`define MPSC_SEQ_IO2      1
`define MPSC_SEQ_INSTR    2
`define MPSC_SEQ_INTR     3
`define MPSC_SEQ_RD1      4
`define MPSC_SEQ_RD2      5
`define MPSC_SEQ_WR       6
`define MPSC_SEQ_WAIT     7
`define MPSC_SEQ_CWF1     8
`define MPSC_SEQ_CWF2     9
`define MPSC_SEQ_W        10
// ****************************************************************
// Function code fields
// ****************************************************************
`define MPSC_FC_FMT2_BIT  6
`define MPSC_FC_EXT_A     6'h31
`define MPSC_FC_EXT_B     6'h33
// ****************************************************************
// Mode bit positions
// ****************************************************************
`define MPSC_MODE_LOAD    0
`define MPSC_MODE_PSTEP   1
`define MPSC_MODE_OPSTEP  2
`define MPSC_MODE_RUN     3
`define MPSC_MODE_W       4
// ****************************************************************
// Timing state count and fixed addresses
// ****************************************************************
`define MPSC_LOAD_ADDR    16'h0140
`define MPSC_TIM_STATES   17
`endif

// ==== design/mpsc_top.v ====
// Maintenance panel sequence control: sequence, timing, F, P, phase, mode
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "mpsc_defines.vh"
// Behaviour
// - Manual instruction select clears other sequences
// - First fetch stores transfer address word
// - Second fetch stores index address word
// - Every designator settable from its pushbutton
// - Wait designator set while awaiting interrupt
// - Timing cycle walks sixteen states plus extra
// - Extra timing state only in 50:61/50:63
// - Function bit six marks format two
// - Function bits zero-five set and clear
// - Program address bits set, one clear
// - Phase step issues phases from selected one
// - Phase clear clears all four selects
// - Load mode clears others, address 00500
// - Phase step mode inhibits memory cycles
module mpsc_top
#(
  parameter P_WIDTH = 16                       // Program address width
)
(
  input  wire                       clk_sys,
  input  wire                       rst_b,
  input  wire                       clk_en,
  // Avalon-MM slave
  input  wire [3:0]                 avs_address,
  input  wire                       avs_read,
  input  wire                       avs_write,
  input  wire [31:0]                avs_writedata,
  output reg  [31:0]                avs_readdata,
  output reg                        avs_waitrequest,
  // Panel pushbuttons (levels, held while pressed)
  input  wire [`MPSC_SEQ_W-1:0]     pb_seq_set,
  input  wire [6:0]                 pb_func_set,
  input  wire [6:0]                 pb_func_clr,
  input  wire                       pb_func_clear_all,
  input  wire [P_WIDTH-1:0]         pb_paddr_set,
  input  wire                       pb_paddr_clear,
  input  wire [3:0]                 pb_phase_sel,
  input  wire                       pb_phase_clear,
  input  wire [`MPSC_MODE_W-1:0]    pb_mode_sel,
  input  wire                       pb_start_step,
  // Machine inputs
  input  wire                       wait_for_intr,
  input  wire                       cpu_cycle_adv,
  input  wire [17:0]                mem_rdata,
  // Panel indicators and machine outputs
  output reg  [`MPSC_SEQ_W-1:0]     sequence_designators,
  output reg  [`MPSC_TIM_STATES-1:0] timing_states,
  output reg  [6:0]                 func_code,
  output reg  [P_WIDTH-1:0]         prog_addr,
  output reg  [3:0]                 phase_select,
  output reg  [`MPSC_MODE_W-1:0]    mode,
  output reg  [3:0]                 phase_pulse,
  output reg                        mem_inhibit,
  output reg                        cm_write,
  output reg                        cm_sel_index,
  output reg  [17:0]                cm_wdata
);

  // ****************************************************************
  // Pushbutton synchroniser and rising-edge detection
  // ****************************************************************
  localparam NPB = `MPSC_SEQ_W + 7 + 7 + 1 + P_WIDTH + 1 + 4 + 1 + `MPSC_MODE_W + 1;
  wire [NPB-1:0] pb_raw;                       // All buttons, flat
  reg  [NPB-1:0] pb_s1_q;                      // First sync stage only
  reg  [NPB-1:0] pb_s2_q;                      // Second sync stage
  reg  [NPB-1:0] pb_s3_q;                      // Delayed for edges
  wire [NPB-1:0] pb_edge;                      // One pulse per press
  assign pb_raw = {pb_seq_set, pb_func_set, pb_func_clr, pb_func_clear_all,
                   pb_paddr_set, pb_paddr_clear, pb_phase_sel, pb_phase_clear,
                   pb_mode_sel, pb_start_step};
  // Edge taken between stages two and three, never on stage one
  assign pb_edge = pb_s2_q & ~pb_s3_q;

  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      pb_s1_q <= {NPB{1'b0}};
      pb_s2_q <= {NPB{1'b0}};
      pb_s3_q <= {NPB{1'b0}};
    end
    else if (clk_en)
    begin
      pb_s1_q <= pb_raw;
      pb_s2_q <= pb_s1_q;
      pb_s3_q <= pb_s2_q;
    end
  end

  // Split edge vector back into named groups
  wire [`MPSC_SEQ_W-1:0]  e_seq;
  wire [6:0]              e_fset;
  wire [6:0]              e_fclr;
  wire                    e_fclr_all;
  wire [P_WIDTH-1:0]      e_pset;
  wire                    e_pclr;
  wire [3:0]              e_phs;
  wire                    e_phclr;
  wire [`MPSC_MODE_W-1:0] e_mode;
  wire                    e_start;
  assign {e_seq, e_fset, e_fclr, e_fclr_all, e_pset, e_pclr, e_phs, e_phclr,
          e_mode, e_start} = pb_edge;

  // ****************************************************************
  // Bus decode: one wait cycle, then answer
  // ****************************************************************
  reg        bus_ack_q;                        // Answer phase marker
  wire       bus_req;                          // Request pending
  wire       wr_go;                            // Write takes effect
  assign bus_req = (avs_read | avs_write) & ~bus_ack_q;
  assign wr_go   = avs_write & bus_ack_q & clk_en;

  // Decode of write address, used for several registers
  function wr_hit;
    input [3:0] a;
    input [3:0] off;
    begin
      wr_hit = (a == off);
    end
  endfunction

  // ****************************************************************
  // Decoded instruction conditions
  // ****************************************************************
  wire is_fmt2;                                // Format-two instruction
  wire ext_ok;                                 // Extra timing state allowed
  assign is_fmt2 = func_code[`MPSC_FC_FMT2_BIT];
  assign ext_ok  = is_fmt2 & ((func_code[5:0] == `MPSC_FC_EXT_A) |
                              (func_code[5:0] == `MPSC_FC_EXT_B));

  // ****************************************************************
  // Sequence designators
  // ****************************************************************
  // Manual instruction select wins; other presses OR in; wait set while idle and held after
  always @(posedge clk_sys)
  begin
    if (!rst_b)
      sequence_designators <= {`MPSC_SEQ_W{1'b0}};
    else if (clk_en)
    begin
      if (e_seq[`MPSC_SEQ_INSTR])
        sequence_designators <= {{(`MPSC_SEQ_W-1){1'b0}}, 1'b1} << `MPSC_SEQ_INSTR;
      else if (wr_go && wr_hit(avs_address, `MPSC_OFF_SEQ))
        sequence_designators <= avs_writedata[`MPSC_SEQ_W-1:0];
      else
      begin
        sequence_designators <= sequence_designators | e_seq;
        if (wait_for_intr)
          sequence_designators[`MPSC_SEQ_WAIT] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Control memory write during the fetch sequences
  // ****************************************************************
  // One write per machine cycle step while a fetch designator stands
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      cm_write     <= 1'b0;
      cm_sel_index <= 1'b0;
      cm_wdata     <= 18'h0_0000;
    end
    else if (clk_en)
    begin
      cm_write <= 1'b0;
      if (cpu_cycle_adv && !mem_inhibit)
      begin
        if (sequence_designators[`MPSC_SEQ_CWF1])
        begin
          cm_write     <= 1'b1;
          cm_sel_index <= 1'b0;
          cm_wdata     <= mem_rdata;
        end
        else if (sequence_designators[`MPSC_SEQ_CWF2])
        begin
          cm_write     <= 1'b1;
          cm_sel_index <= 1'b1;
          cm_wdata     <= mem_rdata;
        end
      end
    end
  end

  // ****************************************************************
  // Main timing cycle: one-hot ring of seventeen states
  // ****************************************************************
  // Index 15 is the last regular state; 16 is the extra state
  localparam [`MPSC_TIM_STATES-1:0] TS_FIRST = 17'h0_0001;
  localparam [`MPSC_TIM_STATES-1:0] TS_LAST  = 17'h0_8000;
  localparam [`MPSC_TIM_STATES-1:0] TS_EXTRA = 17'h1_0000;
  wire tim_step;                               // Advance request
  assign tim_step = cpu_cycle_adv & ~mode[`MPSC_MODE_PSTEP];

  always @(posedge clk_sys)
  begin
    if (!rst_b)
      timing_states <= TS_FIRST;
    else if (clk_en && tim_step)
    begin
      case (timing_states)
        TS_LAST:  timing_states <= ext_ok ? TS_EXTRA : TS_FIRST;
        TS_EXTRA: timing_states <= TS_FIRST;
        default:
        begin
          if (timing_states == {`MPSC_TIM_STATES{1'b0}} || timing_states[16])
            timing_states <= TS_FIRST;
          else
            timing_states <= timing_states << 1;
        end
      endcase
    end
  end

  // ****************************************************************
  // Function code register
  // ****************************************************************
  // Set beats clear when both arrive together
  always @(posedge clk_sys)
  begin
    if (!rst_b)
      func_code <= 7'h00;
    else if (clk_en)
    begin
      if (wr_go && wr_hit(avs_address, `MPSC_OFF_FUNC))
        func_code <= avs_writedata[6:0];
      else if (e_fclr_all)
        func_code <= {func_code[6], 6'h00} | e_fset;
      else
        func_code <= (func_code & ~e_fclr) | e_fset;
    end
  end

  // ****************************************************************
  // Program address register
  // ****************************************************************
  always @(posedge clk_sys)
  begin
    if (!rst_b)
      prog_addr <= {P_WIDTH{1'b0}};
    else if (clk_en)
    begin
      if (e_mode[`MPSC_MODE_LOAD])
        prog_addr <= `MPSC_LOAD_ADDR;
      else if (wr_go && wr_hit(avs_address, `MPSC_OFF_PADDR))
        prog_addr <= avs_writedata[P_WIDTH-1:0];
      else if (e_pclr)
        prog_addr <= e_pset;
      else
        prog_addr <= prog_addr | e_pset;
    end
  end

  // ****************************************************************
  // Mode register: exactly one mode at a time
  // ****************************************************************
  always @(posedge clk_sys)
  begin
    if (!rst_b)
      mode <= {{(`MPSC_MODE_W-1){1'b0}}, 1'b1} << `MPSC_MODE_RUN;
    else if (clk_en)
    begin
      if (e_mode[`MPSC_MODE_LOAD])
        mode <= 4'h1 << `MPSC_MODE_LOAD;
      else if (e_mode[`MPSC_MODE_PSTEP])
        mode <= 4'h1 << `MPSC_MODE_PSTEP;
      else if (e_mode[`MPSC_MODE_OPSTEP])
        mode <= 4'h1 << `MPSC_MODE_OPSTEP;
      else if (e_mode[`MPSC_MODE_RUN])
        mode <= 4'h1 << `MPSC_MODE_RUN;
    end
  end

  // ****************************************************************
  // Phase select and phase step pulses
  // ****************************************************************
  // Phase selects only respond in phase step mode
  reg [3:0] next_phase_q;                      // Next phase to issue
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      phase_select <= 4'h0;
      next_phase_q <= 4'h0;
      phase_pulse  <= 4'h0;
      mem_inhibit  <= 1'b0;
    end
    else if (clk_en)
    begin
      phase_pulse <= 4'h0;
      mem_inhibit <= mode[`MPSC_MODE_PSTEP];
      if (e_phclr)
      begin
        phase_select <= 4'h0;
        next_phase_q <= 4'h0;
      end
      else if (mode[`MPSC_MODE_PSTEP] && e_phs != 4'h0)
      begin
        phase_select <= e_phs;
        next_phase_q <= e_phs;
      end
      else if (mode[`MPSC_MODE_PSTEP] && e_start && next_phase_q != 4'h0)
      begin
        // One phase per press, walking 1-2-3-4 and wrapping
        phase_pulse  <= next_phase_q;
        next_phase_q <= {next_phase_q[2:0], next_phase_q[3]};
      end
    end
  end

  // ****************************************************************
  // Bus answer: read mux and waitrequest
  // ****************************************************************
  // Waitrequest high except in the single answer cycle
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      bus_ack_q       <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      bus_ack_q       <= bus_req;
      avs_waitrequest <= ~bus_req;
      case (avs_address)
        `MPSC_OFF_SEQ:    avs_readdata <= {22'h00_0000, sequence_designators};
        `MPSC_OFF_TIMING: avs_readdata <= {15'h0, timing_states};
        `MPSC_OFF_FUNC:   avs_readdata <= {25'h0, func_code};
        `MPSC_OFF_PADDR:  avs_readdata <= {{(32-P_WIDTH){1'b0}}, prog_addr};
        `MPSC_OFF_PHASE:  avs_readdata <= {24'h0, next_phase_q, phase_select};
        `MPSC_OFF_MODE:   avs_readdata <= {28'h000_0000, mode};
        `MPSC_OFF_STATUS: avs_readdata <= {30'h0, mem_inhibit, ext_ok};
        default:          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // mpsc_top
`default_nettype wire

// ==== verif/mpsc_top_sva.sv ====
// Checker for the maintenance panel sequence control ports
`timescale 1ns/10ps
`default_nettype none
`include "mpsc_defines.vh"
module mpsc_top_chk
#(
  parameter P_WIDTH = 16                      // Program address width
)
(
  input wire logic                        clk_sys,
  input wire logic                        rst_b,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic                        avs_waitrequest,
  input wire logic                        pb_paddr_clear,
  input wire logic [`MPSC_SEQ_W-1:0]      sequence_designators,
  input wire logic [`MPSC_TIM_STATES-1:0] timing_states,
  input wire logic [6:0]                  func_code,
  input wire logic [P_WIDTH-1:0]          prog_addr,
  input wire logic [`MPSC_MODE_W-1:0]     mode,
  input wire logic [3:0]                  phase_pulse,
  input wire logic                        mem_inhibit,
  input wire logic                        cm_write
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Clear press held for at least two samples
  sequence s_clr_press;
    $rose(pb_paddr_clear) ##1 pb_paddr_clear;
  endsequence
  chk_bus_answer: assert property ($rose(avs_read | avs_write) |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_instr_clear: assert property ($rose(sequence_designators[2]) |-> sequence_designators == 10'h004)
    else $error("instruction select left others set");
  chk_timing_onehot: assert property ($onehot(timing_states))
    else $error("timing states not one-hot");
  chk_extra_state: assert property ($rose(timing_states[16]) |-> func_code == 7'h71 || func_code == 7'h73)
    else $error("extra timing state in wrong instruction");
  chk_phase_pulse: assert property (phase_pulse != 4'h0 |-> $onehot(phase_pulse) ##1 phase_pulse == 4'h0)
    else $error("phase pulse not single");
  chk_inhibit_mode: assert property (mode[1] && $past(mode[1]) |-> mem_inhibit)
    else $error("memory not inhibited in phase step");
  chk_fetch_write: assert property (cm_write |-> !mem_inhibit && (sequence_designators[8] || sequence_designators[9]))
    else $error("control memory write outside fetch");
  chk_load_addr: assert property ($rose(mode[0]) |-> ##[0:1] prog_addr == 16'h0140)
    else $error("load mode address wrong");
  chk_mode_onehot: assert property ($onehot(mode))
    else $error("mode not one-hot");
  chk_paddr_clear: assert property (s_clr_press |-> ##[1:3] prog_addr == 16'h0000)
    else $error("address clear failed");
endmodule // mpsc_top_chk
bind mpsc_top mpsc_top_chk #(.P_WIDTH(P_WIDTH)) i_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .pb_paddr_clear(pb_paddr_clear), .sequence_designators(sequence_designators),
  .timing_states(timing_states), .func_code(func_code), .prog_addr(prog_addr), .mode(mode),
  .phase_pulse(phase_pulse), .mem_inhibit(mem_inhibit), .cm_write(cm_write));
`default_nettype wire

// ==== verif/mpsc_panel.sv ====
// Operator panel model: pushbuttons pressed as held levels
`timescale 1ns/10ps
`default_nettype none
module mpsc_panel
(
  input wire logic  clk_sys,
  output logic [9:0]  pb_seq_set,
  output logic [6:0]  pb_func_set,
  output logic [6:0]  pb_func_clr,
  output logic        pb_func_clear_all,
  output logic [15:0] pb_paddr_set,
  output logic        pb_paddr_clear,
  output logic [3:0]  pb_phase_sel,
  output logic        pb_phase_clear,
  output logic [3:0]  pb_mode_sel,
  output logic        pb_start_step
);
  // All buttons released at time zero
  initial
  begin
    {pb_seq_set, pb_func_set, pb_func_clr, pb_func_clear_all, pb_paddr_set} = '0;
    {pb_paddr_clear, pb_phase_sel, pb_phase_clear, pb_mode_sel, pb_start_step} = '0;
  end
  // Drive one button of group g
  task automatic drive(input int g, input int b, input logic v);
    case (g)
      0: pb_seq_set[b] <= v;
      1: pb_func_set[b] <= v;
      2: pb_func_clr[b] <= v;
      3: pb_func_clear_all <= v;
      4: pb_paddr_set[b] <= v;
      5: pb_paddr_clear <= v;
      6: pb_phase_sel[b] <= v;
      7: pb_phase_clear <= v;
      8: pb_mode_sel[b] <= v;
      default: pb_start_step <= v;
    endcase
  endtask
  // Held four cycles so the synchroniser sees it, then released for five
  task automatic press(input int g, input int b);
    @(posedge clk_sys);
    drive(g, b, 1'b1);
    repeat (4) @(posedge clk_sys);
    drive(g, b, 1'b0);
    repeat (5) @(posedge clk_sys);
  endtask
endmodule // mpsc_panel
`default_nettype wire

// ==== verif/mpsc_top_tb.sv ====
// Self-checking testbench for the panel sequence control block
`timescale 1ns/10ps
`default_nettype none
module mpsc_top_tb;
  logic        clk_sys = 1'b0;       // 20 MHz system clock
  logic        rst_b = 1'b0;         // Synchronous reset, active low
  logic        clk_en = 1'b1;        // Clock enable, dropped once to test freezing
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic        wait_for_intr = 1'b0;
  logic        cpu_cycle_adv = 1'b0;
  logic [17:0] mem_rdata = 18'h0_0000;
  logic [9:0]  pb_seq_set, sd;
  logic [6:0]  pb_func_set, pb_func_clr, fc;
  logic [15:0] pb_paddr_set, pa;
  logic [3:0]  pb_phase_sel, pb_mode_sel, ps, md, pp;
  logic        pb_func_clear_all, pb_paddr_clear, pb_phase_clear, pb_start_step;
  logic [31:0] avs_readdata, q;
  logic        avs_waitrequest, mi, cw, csi, cw_seen, cw_idx;
  logic [16:0] ts;
  logic [17:0] cwd, cw_data;
  int          errors = 0;           // Mismatch count
  int          n_compared = 0;       // Comparison count
  int          cyc = 0;              // Cycles since start, for the hang guard
  always #25 clk_sys = ~clk_sys;
  mpsc_top #(.P_WIDTH(16)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pb_seq_set(pb_seq_set), .pb_func_set(pb_func_set), .pb_func_clr(pb_func_clr),
    .pb_func_clear_all(pb_func_clear_all), .pb_paddr_set(pb_paddr_set),
    .pb_paddr_clear(pb_paddr_clear), .pb_phase_sel(pb_phase_sel), .pb_phase_clear(pb_phase_clear),
    .pb_mode_sel(pb_mode_sel), .pb_start_step(pb_start_step), .wait_for_intr(wait_for_intr),
    .cpu_cycle_adv(cpu_cycle_adv), .mem_rdata(mem_rdata), .sequence_designators(sd),
    .timing_states(ts), .func_code(fc), .prog_addr(pa), .phase_select(ps), .mode(md),
    .phase_pulse(pp), .mem_inhibit(mi), .cm_write(cw), .cm_sel_index(csi), .cm_wdata(cwd));
  mpsc_panel i_panel (.clk_sys(clk_sys), .pb_seq_set(pb_seq_set), .pb_func_set(pb_func_set),
    .pb_func_clr(pb_func_clr), .pb_func_clear_all(pb_func_clear_all),
    .pb_paddr_set(pb_paddr_set), .pb_paddr_clear(pb_paddr_clear), .pb_phase_sel(pb_phase_sel),
    .pb_phase_clear(pb_phase_clear), .pb_mode_sel(pb_mode_sel), .pb_start_step(pb_start_step));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One bus cycle; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // One machine cycle advance, watching for a control memory write
  task automatic adv();
    @(posedge clk_sys);
    cpu_cycle_adv <= 1'b1;
    @(posedge clk_sys);
    cpu_cycle_adv <= 1'b0;
    repeat (4)
    begin
      @(posedge clk_sys);
      if (cw === 1'b1)
      begin
        cw_seen = 1'b1;
        cw_idx = csi;
        cw_data = cwd;
      end
    end
  endtask
  // Press start and catch the single phase pulse
  task automatic step(input logic [3:0] e);
    pb_q: fork
      i_panel.press(9, 0);
      begin
        q = 0;
        repeat (12)
        begin
          @(posedge clk_sys);
          if (pp !== 4'h0) q = {28'h0, pp};
        end
      end
    join
    chk("phase_pulse", q, {28'h0, e});
  endtask
  // Verdict and end of run
  task automatic test_done();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard: the tests need about 800 cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      errors++;
      test_done();
    end
  end
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk("mode_rst", md, 4'h8);
    chk("timing_rst", ts, 17'h0_0001);
    bus(1'b0, 4'h5, 0);
    chk("mode_rd", q, 32'h0000_0008);
    bus(1'b1, 4'h5, 32'h0000_0001);
    bus(1'b0, 4'h5, 0);
    chk("mode_ro", q, 32'h0000_0008);
    bus(1'b0, 4'hf, 0);
    chk("unmapped", q, 32'h0000_0000);
    bus(1'b1, 4'h3, 32'h0000_1234);
    bus(1'b0, 4'h3, 0);
    chk("paddr_rw", q, 32'h0000_1234);
    for (int b = 0; b < 7; b++) i_panel.press(1, b);
    chk("func_all", fc, 7'h7f);
    i_panel.press(2, 6);
    chk("fmt2_clr", fc, 7'h3f);
    i_panel.press(3, 0);
    chk("func_clr", fc, 7'h00);
    for (int b = 0; b < 7; b++) if (7'h71 >> b & 1) i_panel.press(1, b);
    chk("func_ext", fc, 7'h71);
    for (int i = 1; i <= 17; i++)
    begin
      adv();
      chk("timing_ext", ts, 17'h0_0001 << (i % 17));
    end
    i_panel.press(2, 6);
    for (int i = 1; i <= 16; i++) adv();
    chk("timing_std", ts, 17'h0_0001);
    // Instruction first, since pressing it clears every other designator
    for (int b = 0; b < 10; b++) i_panel.press(0, (b + 2) % 10);
    chk("seq_all", sd, 10'h3ff);
    i_panel.press(0, 2);
    chk("seq_instr", sd, 10'h004);
    bus(1'b0, 4'h0, 0);
    chk("seq_rd", q, 32'h0000_0004);
    wait_for_intr <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("seq_wait", sd[7], 1'b1);
    wait_for_intr <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      i_panel.press(0, 2);
      i_panel.press(0, 8 + k);
      mem_rdata <= k ? 18'h1_0ff0 : 18'h2_5a5a;
      cw_seen = 1'b0;
      adv();
      chk("cm_write", cw_seen, 1'b1);
      chk("cm_index", cw_idx, k[0]);
      chk("cm_data", cw_data, k ? 18'h1_0ff0 : 18'h2_5a5a);
    end
    for (int b = 0; b < 16; b++) i_panel.press(4, b);
    chk("paddr_set", pa, 16'hffff);
    i_panel.press(5, 0);
    chk("paddr_clr", pa, 16'h0000);
    // A press made while the clock enable is low must leave no trace
    clk_en <= 1'b0;
    i_panel.press(4, 3);
    clk_en <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("freeze", pa, 16'h0000);
    i_panel.press(8, 1);
    chk("mode_ps", md, 4'h2);
    chk("inhibit", mi, 1'b1);
    bus(1'b0, 4'h6, 0);
    chk("status_rd", q, 32'h0000_0002);
    i_panel.press(6, 1);
    chk("phase_sel", ps, 4'h2);
    bus(1'b0, 4'h4, 0);
    chk("phase_rd", q, 32'h0000_0022);
    step(4'h2);
    step(4'h4);
    i_panel.press(7, 0);
    chk("phase_clr", ps, 4'h0);
    i_panel.press(8, 2);
    chk("mode_op", md, 4'h4);
    i_panel.press(8, 0);
    chk("mode_load", md, 4'h1);
    chk("load_addr", pa, 16'h0140);
    chk("inhibit_off", mi, 1'b0);
    test_done();
  end
endmodule // mpsc_top_tb
`default_nettype wire
